// *** hdl/smcp_top.sv ***
// serial command, status protection and array logic of a 16k x 8 memory
// assumes spi pins asynchronous to clk_sys; sck slower than clk_sys/6
`timescale 1ns/100ps
`include "smcp_map.svh"

// How it works
// - status byte: lock, two protect bits, latch
// - status bits start cleared
// - protect bits pick none, quarter, half, all
// - latch clear refuses every write
// - latch set writes only outside protected region
// - lock clear allows protect change any pin
// - lock set needs pin high to change
// - status read allowed at any time except asleep
// - bit 0 never changed by device
// - enable command sets latch
// - disable command clears latch
// - latch cleared at power-up and disable
// - status write ignored unless writable
// - other status bits keep value over reset
// - 16-bit address, low 14 bits used
// - reads stream, wrap to zero
// - read data out on serial output
// - writes stream, wrap, no page limit
// - back to back writes, no busy
// - asleep only wake is obeyed
// - reset leaves sleep
// - first byte decoded as command
// - sample rising edge, shift falling edge
// - one command per select low
module smcp_top (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic power_on_b,
   input wire logic spi_cs_b,
   input wire logic spi_sck,
   input wire logic spi_si,
   input wire logic spi_wp_b,
   input wire logic spi_hold_b,
   output logic spi_so,
   output logic spi_so_oe,
   output logic [7:0] status_q_o,
   output logic asleep_o
);
   // synchronisers
   logic [4:0] meta_q;
   logic [4:0] sync_q;
   logic sck_prev_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         meta_q <= 5'h1f;
         sync_q <= 5'h1f;
         sck_prev_q <= 1'b0;
      end else begin
         meta_q <= {spi_cs_b, spi_sck, spi_si, spi_wp_b, spi_hold_b};
         sync_q <= meta_q;
         sck_prev_q <= sync_q[3];
      end
   end
   logic cs_b;
   logic sck;
   logic si;
   logic wp;
   logic hold_n;
   assign cs_b = sync_q[4];
   assign sck = sync_q[3];
   assign si = sync_q[2];
   assign wp = sync_q[1];
   assign hold_n = sync_q[0];
   logic sck_rise;
   logic sck_fall;
   logic cs_prev_q;
   // hold freezes all transitions seen by the core
   assign sck_rise = hold_n && !cs_b && sck && !sck_prev_q;
   assign sck_fall = hold_n && !cs_b && !sck && sck_prev_q;
   logic cs_end;
   logic cs_start;
   assign cs_end = hold_n && cs_b && !cs_prev_q;
   assign cs_start = hold_n && !cs_b && cs_prev_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cs_prev_q <= 1'b1;
      end else if (hold_n) begin
         cs_prev_q <= cs_b;
      end
   end

   function automatic logic in_protected(input logic [1:0] sel, input logic [13:0] a);
      logic r;
      r = 1'b0;
      unique case (sel)
         2'b00: r = 1'b0;
         2'b01: r = a[13] && a[12];
         2'b10: r = a[13];
         2'b11: r = 1'b1;
      endcase
      return r;
   endfunction : in_protected

   // shift and phase
   smcp_pkg::smcp_phase_e phase_q;
   logic [7:0] shift_q;
   logic [2:0] bitcnt_q;
   logic [3:0] addr_bits_q;
   logic [13:0] addr_q;
   logic is_write_q;
   logic [7:0] cmd_q;
   logic [7:0] status_q;
   logic asleep_q;
   logic [7:0] out_sh_q;
   logic [7:0] rd_byte;
   logic [7:0] shift_next;
   logic byte_done;
   logic fifo_ready;
   logic [7:0] mem [`SMCP_MEM_DEPTH];
   assign shift_next = {shift_q[6:0], si};
   assign byte_done = sck_rise && (bitcnt_q == 3'h7);
   assign rd_byte = mem[addr_q];

   always_ff @(posedge clk_sys) begin
      if (!rst_b || cs_start) begin
         bitcnt_q <= 3'h0;
         shift_q <= 8'h00;
      end else if (sck_rise) begin
         bitcnt_q <= bitcnt_q + 3'h1;
         shift_q <= shift_next;
      end
   end

   logic status_writable;
   // latch, lock and pin decide whether status may change
   assign status_writable = status_q[`SMCP_BIT_WEL] &&
      (!status_q[`SMCP_BIT_LOCK] || wp);

   logic wr_valid;
   logic [21:0] wr_data;
   logic cmd_done;
   assign cmd_done = byte_done && phase_q == smcp_pkg::ST_CMD;

   always_ff @(posedge clk_sys) begin
      if (!rst_b || cs_start) begin
         phase_q <= smcp_pkg::ST_CMD;
         addr_bits_q <= 4'h0;
         addr_q <= '0;
         is_write_q <= 1'b0;
      end else if (byte_done) begin
         unique case (phase_q)
            smcp_pkg::ST_CMD: begin
               // first byte is the command
               if (asleep_q) begin
                  phase_q <= smcp_pkg::ST_IGNORE;
               end else if (shift_next == `SMCP_CMD_READ ||
                            shift_next == `SMCP_CMD_WRITE) begin
                  phase_q <= smcp_pkg::ST_ADDR;
                  is_write_q <= shift_next == `SMCP_CMD_WRITE;
               end else if (shift_next == `SMCP_CMD_CMD_STATUS_READ) begin
                  phase_q <= smcp_pkg::ST_STATUS_RD;
               end else if (shift_next == `SMCP_CMD_CMD_STATUS_WRITE) begin
                  phase_q <= smcp_pkg::ST_STATUS_WR;
               end else begin
                  phase_q <= smcp_pkg::ST_IGNORE;
               end
            end
            smcp_pkg::ST_ADDR: begin
               addr_bits_q <= addr_bits_q + 4'h8;
               // only the low 14 address bits are kept
               addr_q <= {addr_q[5:0], shift_next};
               if (addr_bits_q == 4'h8) begin
                  phase_q <= is_write_q ? smcp_pkg::ST_WDATA : smcp_pkg::ST_RDATA;
               end
            end
            smcp_pkg::ST_RDATA: addr_q <= addr_q + 14'h1;
            smcp_pkg::ST_WDATA: addr_q <= addr_q + 14'h1;
            smcp_pkg::ST_STATUS_RD: phase_q <= smcp_pkg::ST_STATUS_RD;
            smcp_pkg::ST_STATUS_WR: phase_q <= smcp_pkg::ST_IGNORE;
            smcp_pkg::ST_IGNORE: phase_q <= smcp_pkg::ST_IGNORE;
            default: phase_q <= smcp_pkg::ST_IGNORE;
         endcase
      end
   end

   // command byte held for the select-rise actions
   always_ff @(posedge clk_sys) begin
      if (!rst_b || cs_start) begin
         cmd_q <= 8'h00;
      end else if (cmd_done) begin
         cmd_q <= shift_next;
      end
   end
   logic lone_cmd_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_b || cs_start) begin
         lone_cmd_q <= 1'b0;
      end else if (sck_rise) begin
         lone_cmd_q <= cmd_done;
      end
   end

   // status register; only the latch is volatile
   always_ff @(posedge clk_sys) begin
      if (!power_on_b) begin
         status_q <= `SMCP_STATUS_RST;
      end else if (!rst_b) begin
         status_q[`SMCP_BIT_WEL] <= 1'b0;
      end else if (byte_done && phase_q == smcp_pkg::ST_STATUS_WR && status_writable) begin
         // bits 7 to 2 and 0 stored; latch kept
         status_q <= {shift_next[7:2], status_q[`SMCP_BIT_WEL], shift_next[0]};
      end else if (cs_end && lone_cmd_q && !asleep_q) begin
         if (cmd_q == `SMCP_CMD_CMD_ENABLE_WRITES) begin
            status_q[`SMCP_BIT_WEL] <= 1'b1;
         end else if (cmd_q == `SMCP_CMD_CMD_DISABLE_WRITES) begin
            status_q[`SMCP_BIT_WEL] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         asleep_q <= 1'b0;
      end else if (cs_end && lone_cmd_q) begin
         if (!asleep_q && cmd_q == `SMCP_CMD_SLEEP) begin
            asleep_q <= 1'b1;
         end else if (asleep_q && cmd_q == `SMCP_CMD_WAKE) begin
            asleep_q <= 1'b0;
         end
      end
   end

   // accepted write bytes queue for the array
   assign wr_valid = byte_done && phase_q == smcp_pkg::ST_WDATA &&
      status_q[`SMCP_BIT_WEL] &&
      !in_protected(status_q[3:2], addr_q);
   assign wr_data = {addr_q, shift_next};
   logic q_valid;
   logic [21:0] q_data;
   smcp_fifo #(.WIDTH(22), .DEPTH(`SMCP_FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_valid(wr_valid),
      .in_ready(fifo_ready),
      .in_data(wr_data),
      .out_valid(q_valid),
      .out_ready(1'b1),
      .out_data(q_data)
   );
   always_ff @(posedge clk_sys) begin
      if (q_valid) begin
         mem[q_data[21:8]] <= q_data[7:0];
      end
   end

   // output shifter loads on the falling edge that opens a byte
   logic load_slot;
   assign load_slot = sck_fall && bitcnt_q == 3'h0;
   always_ff @(posedge clk_sys) begin
      if (!rst_b || cs_start) begin
         out_sh_q <= 8'h00;
      end else if (load_slot && phase_q == smcp_pkg::ST_RDATA) begin
         out_sh_q <= rd_byte;
      end else if (load_slot && phase_q == smcp_pkg::ST_STATUS_RD) begin
         out_sh_q <= status_q;
      end else if (sck_fall) begin
         out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
   end
   logic out_phase;
   assign out_phase = phase_q == smcp_pkg::ST_RDATA || phase_q == smcp_pkg::ST_STATUS_RD;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         spi_so <= 1'b0;
         spi_so_oe <= 1'b0;
      end else begin
         spi_so_oe <= !cs_b && hold_n && out_phase;
         if (load_slot && phase_q == smcp_pkg::ST_RDATA) begin
            spi_so <= rd_byte[7];
         end else if (load_slot && phase_q == smcp_pkg::ST_STATUS_RD) begin
            spi_so <= status_q[7];
         end else if (sck_fall) begin
            spi_so <= out_sh_q[6];
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         status_q_o <= 8'h00;
         asleep_o <= 1'b0;
      end else begin
         status_q_o <= status_q;
         asleep_o <= asleep_q;
      end
   end

   sequence s_cmd_enable_writes_frame;
      cs_end && lone_cmd_q && !asleep_q && cmd_q == `SMCP_CMD_CMD_ENABLE_WRITES;
   endsequence
   sequence s_cmd_disable_writes_frame;
      cs_end && lone_cmd_q && !asleep_q && cmd_q == `SMCP_CMD_CMD_DISABLE_WRITES;
   endsequence
   sequence s_sleep_frame;
      cs_end && lone_cmd_q && !asleep_q && cmd_q == `SMCP_CMD_SLEEP;
   endsequence
   sequence s_wake_frame;
      cs_end && lone_cmd_q && asleep_q && cmd_q == `SMCP_CMD_WAKE;
   endsequence
   sequence s_status_try;
      byte_done && phase_q == smcp_pkg::ST_STATUS_WR;
   endsequence
   sequence s_status_refused;
      byte_done && phase_q == smcp_pkg::ST_STATUS_WR && !status_writable;
   endsequence
   sequence s_top_byte;
      byte_done && addr_q == 14'h3fff &&
         (phase_q == smcp_pkg::ST_RDATA || phase_q == smcp_pkg::ST_WDATA);
   endsequence
   AST_CMD_ENABLE_WRITES_SETS: assert property (@(posedge clk_sys)
      disable iff (!rst_b || !power_on_b) s_cmd_enable_writes_frame |=> status_q[1])
      else $error("latch not set");
   AST_CMD_DISABLE_WRITES_CLR: assert property (@(posedge clk_sys)
      disable iff (!rst_b || !power_on_b) s_cmd_disable_writes_frame |=> !status_q[1])
      else $error("latch not cleared");
   AST_NO_WR_NOLATCH: assert property (@(posedge clk_sys)
      disable iff (!rst_b) !status_q[1] |-> !wr_valid)
      else $error("write without latch");
   AST_PROT_ALL: assert property (@(posedge clk_sys)
      disable iff (!rst_b) status_q[3:2] == 2'b11 |-> !wr_valid)
      else $error("write into protected");
   AST_PROT_QUARTER: assert property (@(posedge clk_sys)
      disable iff (!rst_b) wr_valid && status_q[3:2] == 2'b01 |-> !(addr_q[13] && addr_q[12]))
      else $error("write into protected quarter");
   AST_PROT_HALF: assert property (@(posedge clk_sys)
      disable iff (!rst_b) wr_valid && status_q[3:2] == 2'b10 |-> !addr_q[13])
      else $error("write into protected half");
   AST_LOCKED: assert property (@(posedge clk_sys)
      disable iff (!rst_b || !power_on_b)
      status_q[7] && !wp && !(cs_end && lone_cmd_q) |=> $stable(status_q[7:2]))
      else $error("locked status changed");
   AST_CMD_STATUS_WRITE_REFUSED: assert property (@(posedge clk_sys)
      disable iff (!rst_b || !power_on_b) s_status_refused |=> $stable(status_q))
      else $error("refused status write took effect");
   AST_CMD_STATUS_WRITE_KEEPS_LATCH: assert property (@(posedge clk_sys)
      disable iff (!rst_b || !power_on_b) s_status_try |=> $stable(status_q[1]))
      else $error("status write moved the latch");
   AST_BIT0_HELD: assert property (@(posedge clk_sys)
      disable iff (!rst_b || !power_on_b)
      !(byte_done && phase_q == smcp_pkg::ST_STATUS_WR) |=> $stable(status_q[0]))
      else $error("bit 0 changed by device");
   AST_SLEEP_IGN: assert property (@(posedge clk_sys)
      disable iff (!rst_b) asleep_q && cmd_done |=> phase_q == smcp_pkg::ST_IGNORE)
      else $error("command taken asleep");
   AST_SLEEP_SETS: assert property (@(posedge clk_sys)
      disable iff (!rst_b) s_sleep_frame |=> asleep_q)
      else $error("sleep not entered");
   AST_WAKE_CLR: assert property (@(posedge clk_sys)
      disable iff (!rst_b) s_wake_frame |=> !asleep_q)
      else $error("wake not taken");
   AST_ADDR_WRAP: assert property (@(posedge clk_sys)
      disable iff (!rst_b) s_top_byte |=> addr_q == 14'h0000)
      else $error("address did not wrap");
   AST_IGNORE_HOLDS: assert property (@(posedge clk_sys)
      disable iff (!rst_b) phase_q == smcp_pkg::ST_IGNORE && !cs_start |=>
      phase_q == smcp_pkg::ST_IGNORE)
      else $error("ignored frame resumed");
   AST_HOLD_FLOAT: assert property (@(posedge clk_sys)
      disable iff (!rst_b) !hold_n |=> !spi_so_oe)
      else $error("output driven in hold");
   AST_QUIET_NO_READ: assert property (@(posedge clk_sys)
      disable iff (!rst_b) !out_phase |=> !spi_so_oe)
      else $error("output driven outside a read");
   AST_FIFO_ROOM: assert property (@(posedge clk_sys)
      disable iff (!rst_b) wr_valid |-> fifo_ready)
      else $error("write queue overflow");
endmodule : smcp_top

// *** hdl/smcp_map.svh ***
// constants for the serial memory command and protect block
// assumes inclusion by bare name from the top module
`ifndef SMCP_MAP_SVH
`define SMCP_MAP_SVH
`define SMCP_BIT_LOCK 7
`define SMCP_BIT_PSEL_HI 3
`define SMCP_BIT_PSEL_LO 2
`define SMCP_BIT_WEL 1
`define SMCP_STATUS_RST 8'h00
`define SMCP_CMD_CMD_ENABLE_WRITES 8'h06
`define SMCP_CMD_CMD_DISABLE_WRITES 8'h04
`define SMCP_CMD_CMD_STATUS_READ 8'h05
`define SMCP_CMD_CMD_STATUS_WRITE 8'h01
`define SMCP_CMD_READ 8'h03
`define SMCP_CMD_WRITE 8'h02
`define SMCP_CMD_SLEEP 8'hb9
`define SMCP_CMD_WAKE 8'hab
`define SMCP_ADDR_W 14
`define SMCP_MEM_DEPTH 16384
`define SMCP_FIFO_DEPTH 8
`endif

// *** hdl/smcp_pkg.sv ***
// types shared by the serial memory command and protect block
// assumes the constants header is compiled alongside
package smcp_pkg;
   typedef enum logic [2:0] {
      ST_CMD = 3'b000,
      ST_ADDR = 3'b001,
      ST_RDATA = 3'b010,
      ST_WDATA = 3'b011,
      ST_STATUS_RD = 3'b100,
      ST_STATUS_WR = 3'b101,
      ST_IGNORE = 3'b110
   } smcp_phase_e;
endpackage : smcp_pkg

// *** hdl/smcp_fifo.sv ***
// small synchronous fifo, valid and ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module smcp_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;
   assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign out_data = mem[rd_q[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule : smcp_fifo

// *** verif/smcp_host_model.sv ***
// spi host model: mode 0 or mode 3 frames, msb first, link clock built from clk_sys
// assumes clk_sys at 8 ns, so ten cycles make each 80 ns half period
`timescale 1ns/100ps
module smcp_host_model (
   input wire logic clk_sys,
   input wire logic mode3,
   output logic spi_cs_b,
   output logic spi_sck,
   output logic spi_si,
   input wire logic spi_so,
   input wire logic spi_so_oe
);
   initial begin
      spi_cs_b = 1'b1;
      spi_sck = 1'b0;
      spi_si = 1'b0;
   end
   task automatic half();
      repeat (10) @(posedge clk_sys);
      #1;
   endtask : half
   // sck settles at its idle level before select falls: low mode 0, high mode 3
   task automatic start();
      if (spi_sck !== mode3) begin
         spi_sck = mode3;
         half();
      end
      spi_cs_b = 1'b0;
      half();
   endtask : start
   // undriven so reads as unknown so it never matches
   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         spi_sck = 1'b0;
         spi_si = tx[i];
         half();
         spi_sck = 1'b1;
         rx[i] = spi_so_oe ? spi_so : 1'bx;
         half();
      end
   endtask : xbyte
   // ends on a byte boundary, idles long enough for wake recovery
   task automatic stop();
      spi_sck = mode3;
      half();
      spi_cs_b = 1'b1;
      spi_si = ~spi_si;
      repeat (4) half();
   endtask : stop
endmodule : smcp_host_model

// *** verif/tb_top.sv ***
// self-checking bench for the serial memory command and protect block
// assumes the host model drives the spi pins; hold is driven by the bench
`timescale 1ns/100ps
module tb_top;
   logic clk_sys, rst_b, power_on_b, spi_wp_b, spi_so, spi_so_oe, asleep_o;
   logic spi_cs_b, spi_sck, spi_si, spi_hold_b, mode3;
   logic [7:0] status_q_o, s, r, v;
   logic [7:0] rb [3];
   logic [7:0] ex [3];
   logic [15:0] lim [4] = '{16'h4000, 16'h3000, 16'h2000, 16'h0000};
   logic [15:0] pa [3] = '{16'h0000, 16'h2000, 16'h3000};
   int failures = 0;
   int n_tests = 0;
   int cyc = 0;
   smcp_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .power_on_b(power_on_b),
      .spi_cs_b(spi_cs_b), .spi_sck(spi_sck), .spi_si(spi_si), .spi_wp_b(spi_wp_b),
      .spi_hold_b(spi_hold_b), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
      .status_q_o(status_q_o), .asleep_o(asleep_o));
   smcp_host_model host (.clk_sys(clk_sys), .mode3(mode3), .spi_cs_b(spi_cs_b),
      .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 80000) begin
         failures++;
         results();
      end
   end
   task automatic results();
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask : chk
   task automatic cmd1(input logic [7:0] c);
      host.start();
      host.xbyte(c, r);
      host.stop();
   endtask : cmd1
   task automatic hdr(input logic [7:0] c, input logic [15:0] a);
      host.start();
      host.xbyte(c, r);
      host.xbyte(a[15:8], r);
      host.xbyte(a[7:0], r);
   endtask : hdr
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n);
      hdr(8'h02, a);
      for (int i = 0; i < n; i++) host.xbyte(d + 8'(i), r);
      host.stop();
   endtask : wr
   task automatic rd(input logic [15:0] a);
      hdr(8'h03, a);
      for (int i = 0; i < 3; i++) host.xbyte(8'h00, rb[i]);
      host.stop();
   endtask : rd
   task automatic cmd_status_read();
      host.start();
      host.xbyte(8'h05, r);
      host.xbyte(8'h00, s);
      chk({7'h0, spi_so_oe}, 8'h01);
      host.stop();
   endtask : cmd_status_read
   // one command byte and exactly one status byte
   task automatic cmd_status_write(input logic [7:0] b);
      host.start();
      host.xbyte(8'h01, r);
      host.xbyte(b, r);
      host.stop();
   endtask : cmd_status_write
   task automatic pulse_rst();
      rst_b = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask : pulse_rst
   task automatic t_latch();
      chk(status_q_o, 8'h00);
      cmd1(8'h06);
      cmd_status_read();
      chk(s, 8'h02);
      chk(status_q_o, 8'h02);
      cmd1(8'h04);
      cmd_status_read();
      chk(s, 8'h00);
   endtask : t_latch
   task automatic t_stream();
      cmd1(8'h06);
      wr(16'hffff, 8'ha5, 3);
      wr(16'h1000, 8'h30, 1);
      rd(16'h3fff);
      chk(rb[0], 8'ha5);
      chk(rb[1], 8'ha6);
      chk(rb[2], 8'ha7);
      rd(16'h1000);
      chk(rb[0], 8'h30);
      cmd1(8'h04);
      wr(16'h0000, 8'h11, 2);
      cmd_status_write(8'h0c);
      rd(16'h3fff);
      chk(rb[1], 8'ha6);
      chk(status_q_o, 8'h00);
   endtask : t_stream
   task automatic t_protect();
      spi_wp_b = 1'b0;
      for (int bp = 0; bp < 4; bp++) begin
         cmd1(8'h06);
         cmd_status_write({4'h0, 2'(bp), 2'b00});
         cmd_status_read();
         chk(s, {4'h0, 2'(bp), 2'b10});
         for (int k = 0; k < 3; k++) begin
            v = 8'h40 + 8'(bp * 4 + k);
            wr(pa[k], v, 1);
            if (pa[k] < lim[bp]) ex[k] = v;
         end
         for (int k = 0; k < 3; k++) begin
            rd(pa[k]);
            chk(rb[0], ex[k]);
         end
      end
      cmd_status_write(8'h04);
      wr(16'h3fff, 8'h77, 2);
      rd(16'h3fff);
      chk(rb[0], 8'ha5);
      chk(rb[1], 8'h78);
      cmd_status_write(8'h00);
   endtask : t_protect
   task automatic t_lock();
      spi_wp_b = 1'b1;
      cmd1(8'h06);
      cmd_status_write(8'h80);
      cmd_status_read();
      chk(s, 8'h82);
      spi_wp_b = 1'b0;
      cmd_status_write(8'h0c);
      cmd_status_read();
      chk(s, 8'h82);
      spi_wp_b = 1'b1;
      cmd_status_write(8'h01);
      cmd_status_read();
      chk(s, 8'h03);
      cmd1(8'h04);
      cmd_status_write(8'h00);
      chk(status_q_o, 8'h01);
      cmd1(8'h06);
      pulse_rst();
      chk(status_q_o, 8'h01);
   endtask : t_lock
   task automatic t_sleep();
      cmd1(8'hb9);
      chk({7'h0, asleep_o}, 8'h01);
      cmd1(8'h06);
      chk(status_q_o, 8'h01);
      cmd1(8'hab);
      chk({7'h0, asleep_o}, 8'h00);
      cmd1(8'h06);
      chk(status_q_o, 8'h03);
      cmd1(8'hb9);
      pulse_rst();
      chk({7'h0, asleep_o}, 8'h00);
      host.start();
      host.xbyte(8'h55, r);
      host.xbyte(8'h00, r);
      chk({7'h0, spi_so_oe}, 8'h00);
      host.stop();
   endtask : t_sleep
   // burst longer than the write queue, read back through the pins
   task automatic t_burst();
      cmd1(8'h06);
      wr(16'h0200, 8'hc0, 10);
      hdr(8'h03, 16'h0200);
      for (int i = 0; i < 10; i++) begin
         host.xbyte(8'h00, v);
         chk(v, 8'hc0 + 8'(i));
      end
      host.stop();
      chk({7'h0, spi_so_oe}, 8'h00);
   endtask : t_burst
   task automatic t_mode3();
      mode3 = 1'b1;
      cmd_status_read();
      chk(s, 8'h03);
      wr(16'h0010, 8'h5a, 2);
      rd(16'h0010);
      chk(rb[0], 8'h5a);
      chk(rb[1], 8'h5b);
      cmd1(8'h04);
      cmd_status_read();
      chk(s, 8'h01);
      mode3 = 1'b0;
   endtask : t_mode3
   task automatic t_hold();
      host.start();
      host.xbyte(8'h05, r);
      host.xbyte(8'h00, s);
      spi_hold_b = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      chk({7'h0, spi_so_oe}, 8'h00);
      spi_hold_b = 1'b1;
      repeat (6) @(posedge clk_sys);
      #1;
      chk({7'h0, spi_so_oe}, 8'h01);
      host.xbyte(8'h00, s);
      chk(s, 8'h01);
      host.stop();
   endtask : t_hold
   initial begin
      rst_b = 1'b0;
      power_on_b = 1'b0;
      spi_wp_b = 1'b1;
      spi_hold_b = 1'b1;
      mode3 = 1'b0;
      repeat (5) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      power_on_b = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      t_latch();
      t_stream();
      t_protect();
      t_lock();
      t_sleep();
      t_burst();
      t_mode3();
      t_hold();
      results();
   end
endmodule : tb_top
